// File: core/gpib_glue_pkg.sv
// shared constants for the dual instrument-port glue block
// What this block does
// - address bits 4..6 pick one strobe
// - four strobes: two ports, latch read, write
// - strobes only while io strobe active
// - address bits 1..3 index port registers
// - eight read and eight write registers
// - one data register each way, rest control
// - write line sets direction of transfer
// - general port uses data lanes 0..7
// - system port uses data lanes 8..15
// - data transceiver direction follows talk enable
// - control lines direction from talk, ctrl, atn
// - sender presents byte and drives DAV
// - accept data only after own listen address; commands unless talking
// - service request after byte, read re-arms
// - handshake intervals timed by host clock
// - test latch returns written value unchanged
// - port selects at 1FE10X and 1FE11X
// - latch read 1FF920, latch write 1FF930
package gpib_glue_pkg;
  localparam int BYTE_W = 8; // one port data lane
  localparam int CTL_W = 8; // handshake plus control lines
  localparam int MODE_W = 6; // width of the mode register
  localparam int LADDR_W = 5; // listen address width
  // upper address windows, address bits 23..7
  localparam logic [16:0] PORT_REGION = 17'h03FC2;
  localparam logic [16:0] LATCH_REGION = 17'h03FF2;
  // strobe codes on address bits 6..4, also strobe vector positions
  localparam int STB_GENERAL = 0;
  localparam int STB_SYSTEM = 1;
  localparam int STB_LREAD = 2;
  localparam int STB_LWRITE = 3;
  // lane positions of the control/handshake bundle
  localparam int CTL_DAV = 0;
  localparam int CTL_NRFD = 1;
  localparam int CTL_NDAC = 2;
  localparam int CTL_ATN = 3;
  localparam int CTL_EOI = 4;
  localparam int CTL_IFC = 5;
  localparam int CTL_REN = 6;
  localparam int CTL_SRQ = 7;
  // lines driven both ways when enabled; others are open collector
  localparam logic [7:0] CTL_TRISTATE = 8'h79;
  // port register indices
  localparam logic [2:0] REG_DATA = 3'h0;
  localparam logic [2:0] REG_ADDR = 3'h1;
  localparam logic [2:0] REG_STATUS = 3'h1;
  localparam logic [2:0] REG_MODE = 3'h2;
  // mode bits
  localparam int MODE_TALK = 0;
  localparam int MODE_CTRL = 1;
  localparam int MODE_ATN = 2;
  localparam int MODE_REN = 3;
  localparam int MODE_IFC = 4;
  localparam int MODE_EOI = 5;
  // status bits
  localparam int ST_RXFULL = 0;
  localparam int ST_TXBUSY = 1;
  localparam int ST_LISTEN = 2;
  localparam int ST_TALK = 3;
  localparam int ST_CTRL = 4;
  // bus commands
  localparam logic [2:0] LISTEN_GROUP = 3'h1;
  localparam logic [7:0] UNLISTEN = 8'h3F;
  // handshake timing in host clock periods
  localparam int HOST_CLK_NS = 200;
  localparam int SETTLE_NS = 2000;
  localparam int SETTLE_TICKS = (SETTLE_NS + HOST_CLK_NS - 1) / HOST_CLK_NS;
endpackage

// File: core/port_link_if.sv
// link between the glue hub and one port controller
`timescale 1ns/10ps
`default_nettype none
interface port_link_if;
  logic wr; // one-cycle register write
  logic rd_done; // one-cycle pulse at end of a read
  logic [2:0] idx; // register index
  logic [7:0] wdata; // write byte
  logic [7:0] rdata; // read byte
  logic tick; // rising edge of host 5 MHz clock
  logic [7:0] ctl_seen; // wire lines, true = asserted
  logic [7:0] dio_seen; // wire data, true = one
  logic [7:0] ctl_assert; // lines this port asserts
  logic [7:0] dio_drive; // byte this port sends
  logic talk; // talk enable
  logic ctrl; // controller active
  logic srq_n; // service request to host, low active
  modport hub (output wr, rd_done, idx, wdata, tick, ctl_seen, dio_seen,
    input rdata, ctl_assert, dio_drive, talk, ctrl, srq_n);
  modport port (input wr, rd_done, idx, wdata, tick, ctl_seen, dio_seen,
    output rdata, ctl_assert, dio_drive, talk, ctrl, srq_n);
endinterface
`default_nettype wire

// File: core/gpib_port.sv
// one talker/listener port controller with source and acceptor handshake
`timescale 1ns/10ps
`default_nettype none
module gpib_port (
  input wire logic clk,
  input wire logic rst,
  port_link_if.port lnk
);
  typedef enum {SRC_IDLE, SRC_SETTLE, SRC_WAIT_ACC, SRC_RELEASE} src_type;
  typedef enum {ACC_READY, ACC_TAKEN} acc_type;
  localparam int CNT_W = $clog2(gpib_glue_pkg::SETTLE_TICKS + 1);
  localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(gpib_glue_pkg::SETTLE_TICKS - 1);

  logic [gpib_glue_pkg::MODE_W-1:0] mode_q, mode_d; // talk, ctrl, line requests
  logic [gpib_glue_pkg::LADDR_W-1:0] laddr_q, laddr_d; // own listen address
  logic [7:0] txbyte_q, txbyte_d, rxbyte_q, rxbyte_d;
  logic txpend_q, txpend_d, rxfull_q, rxfull_d, listen_q, listen_d, srq_n_q, srq_n_d;
  src_type src_q, src_d;
  acc_type acc_q, acc_d;
  logic [CNT_W-1:0] cnt_q, cnt_d; // settle ticks
  logic dav_in, nrfd_in, ndac_in, atn_in, accept_en;
  logic [7:0] ctl_v, rd_v;

  assign dav_in = lnk.ctl_seen[gpib_glue_pkg::CTL_DAV];
  assign nrfd_in = lnk.ctl_seen[gpib_glue_pkg::CTL_NRFD];
  assign ndac_in = lnk.ctl_seen[gpib_glue_pkg::CTL_NDAC];
  assign atn_in = lnk.ctl_seen[gpib_glue_pkg::CTL_ATN];
  // commands are taken unless talking; data only once addressed and emptied
  assign accept_en = atn_in || (listen_q && !rxfull_q);

  // next state: source, acceptor, host access
  always_comb begin
    mode_d = mode_q;
    laddr_d = laddr_q;
    txbyte_d = txbyte_q;
    txpend_d = txpend_q;
    rxbyte_d = rxbyte_q;
    rxfull_d = rxfull_q;
    listen_d = listen_q;
    src_d = src_q;
    acc_d = acc_q;
    cnt_d = cnt_q;
    // source handshake, paced by the host clock
    unique case (src_q)
      SRC_IDLE: if (txpend_q && mode_q[gpib_glue_pkg::MODE_TALK]) begin
        src_d = SRC_SETTLE;
        cnt_d = '0;
      end
      SRC_SETTLE: if (lnk.tick) begin
        if (cnt_q != SETTLE_LAST) begin
          cnt_d = cnt_q + 1'b1;
        end else if (!nrfd_in) begin
          src_d = SRC_WAIT_ACC;
        end
      end
      SRC_WAIT_ACC: if (!ndac_in) begin
        src_d = SRC_RELEASE;
        txpend_d = 1'b0;
      end
      SRC_RELEASE: if (ndac_in) begin
        src_d = SRC_IDLE;
      end
    endcase
    // host read of the data byte re-arms the acceptor
    if (lnk.rd_done && lnk.idx == gpib_glue_pkg::REG_DATA) begin
      rxfull_d = 1'b0;
    end
    // acceptor handshake; a byte arriving with the read wins
    unique case (acc_q)
      ACC_READY: if (dav_in && accept_en && !mode_q[gpib_glue_pkg::MODE_TALK]) begin
        acc_d = ACC_TAKEN;
        if (atn_in) begin
          if (lnk.dio_seen == gpib_glue_pkg::UNLISTEN) begin
            listen_d = 1'b0;
          end else if (lnk.dio_seen == {gpib_glue_pkg::LISTEN_GROUP, laddr_q}) begin
            listen_d = 1'b1;
          end
        end else begin
          rxbyte_d = lnk.dio_seen;
          rxfull_d = 1'b1;
        end
      end
      ACC_TAKEN: if (!dav_in) begin
        acc_d = ACC_READY;
      end
    endcase
    // host writes; a new byte set beats the sender clearing pending
    if (lnk.wr) begin
      unique case (lnk.idx)
        gpib_glue_pkg::REG_DATA: begin
          txbyte_d = lnk.wdata;
          txpend_d = 1'b1;
        end
        gpib_glue_pkg::REG_ADDR: laddr_d = lnk.wdata[gpib_glue_pkg::LADDR_W-1:0];
        gpib_glue_pkg::REG_MODE: mode_d = lnk.wdata[gpib_glue_pkg::MODE_W-1:0];
        default: ;
      endcase
    end
    srq_n_d = !rxfull_d;
  end

  // state registers
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_q <= '0;
      laddr_q <= '0;
      txbyte_q <= '0;
      txpend_q <= 1'b0;
      rxbyte_q <= '0;
      rxfull_q <= 1'b0;
      listen_q <= 1'b0;
      srq_n_q <= 1'b1;
      src_q <= SRC_IDLE;
      acc_q <= ACC_READY;
      cnt_q <= '0;
    end else begin
      mode_q <= mode_d;
      laddr_q <= laddr_d;
      txbyte_q <= txbyte_d;
      txpend_q <= txpend_d;
      rxbyte_q <= rxbyte_d;
      rxfull_q <= rxfull_d;
      listen_q <= listen_d;
      srq_n_q <= srq_n_d;
      src_q <= src_d;
      acc_q <= acc_d;
      cnt_q <= cnt_d;
    end
  end

  // line requests and read mux; only the controller may assert atn, ifc, ren
  always_comb begin
    ctl_v = '0;
    ctl_v[gpib_glue_pkg::CTL_DAV] = (src_q == SRC_WAIT_ACC);
    ctl_v[gpib_glue_pkg::CTL_NRFD] = !(acc_q == ACC_READY && accept_en);
    ctl_v[gpib_glue_pkg::CTL_NDAC] = (acc_q == ACC_READY);
    ctl_v[gpib_glue_pkg::CTL_EOI] = mode_q[gpib_glue_pkg::MODE_EOI] && (src_q == SRC_WAIT_ACC);
    ctl_v[gpib_glue_pkg::CTL_ATN] = mode_q[gpib_glue_pkg::MODE_ATN] && mode_q[gpib_glue_pkg::MODE_CTRL];
    ctl_v[gpib_glue_pkg::CTL_IFC] = mode_q[gpib_glue_pkg::MODE_IFC] && mode_q[gpib_glue_pkg::MODE_CTRL];
    ctl_v[gpib_glue_pkg::CTL_REN] = mode_q[gpib_glue_pkg::MODE_REN] && mode_q[gpib_glue_pkg::MODE_CTRL];
    rd_v = '0;
    unique case (lnk.idx)
      gpib_glue_pkg::REG_DATA: rd_v = rxbyte_q;
      gpib_glue_pkg::REG_STATUS: begin
        rd_v[gpib_glue_pkg::ST_RXFULL] = rxfull_q;
        rd_v[gpib_glue_pkg::ST_TXBUSY] = txpend_q;
        rd_v[gpib_glue_pkg::ST_LISTEN] = listen_q;
        rd_v[gpib_glue_pkg::ST_TALK] = mode_q[gpib_glue_pkg::MODE_TALK];
        rd_v[gpib_glue_pkg::ST_CTRL] = mode_q[gpib_glue_pkg::MODE_CTRL];
      end
      default: ;
    endcase
  end

  assign lnk.ctl_assert = ctl_v;
  assign lnk.rdata = rd_v;
  assign lnk.dio_drive = (src_q != SRC_IDLE) ? txbyte_q : '0;
  assign lnk.talk = mode_q[gpib_glue_pkg::MODE_TALK];
  assign lnk.ctrl = mode_q[gpib_glue_pkg::MODE_CTRL];
  assign lnk.srq_n = srq_n_q;

  default clocking port_cb @(posedge clk); endclocking
  default disable iff (rst);

  a_srq_after_byte: assert property (
    (acc_q == ACC_READY && dav_in && accept_en && !atn_in && !mode_q[gpib_glue_pkg::MODE_TALK])
      |=> !lnk.srq_n && rxfull_q)
    else $error("service request missing after accepted byte");
  a_dav_needs_ready: assert property (
    $rose(src_q == SRC_WAIT_ACC) |-> !$past(nrfd_in) && $past(lnk.tick))
    else $error("data valid asserted without ready or host tick");
  a_data_only_listen: assert property (
    $rose(rxfull_q) |-> $past(listen_q) && !$past(atn_in))
    else $error("byte stored while not addressed to listen");
endmodule
`default_nettype wire

// File: core/gpib_glue_top.sv
// host glue for two instrument ports and the bus self-test latch
`timescale 1ns/10ps
`default_nettype none
module gpib_glue_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic [23:1] host_addr,
  input wire logic [15:0] host_data_in,
  output logic [15:0] host_data_out,
  output logic [15:0] host_data_oe,
  input wire logic io_strobe_n,
  input wire logic write_n,
  input wire logic host_clk5,
  output logic general_port_select_n,
  output logic system_port_select_n,
  output logic test_latch_read_n,
  output logic test_latch_write_n,
  output logic [2:0] port_reg_index,
  output logic general_port_service_req_n,
  output logic system_port_service_req_n,
  output logic [1:0] talk_enable_n,
  input wire logic [1:0][7:0] gpib_dio_n_in,
  output logic [1:0][7:0] gpib_dio_n_out,
  output logic [1:0][7:0] gpib_dio_oe,
  input wire logic [1:0][7:0] gpib_ctl_n_in,
  output logic [1:0][7:0] gpib_ctl_n_out,
  output logic [1:0][7:0] gpib_ctl_oe
);
  localparam int NP = 2; // port 0 general, port 1 system
  localparam int BW = gpib_glue_pkg::BYTE_W;
  localparam int CW = gpib_glue_pkg::CTL_W;
  localparam int SYNC_W = 3 + 23 + 16 + 2 * NP * BW;

  // picks the strobe for an address; a valid code sets one bit
  function automatic logic [3:0] decode_sel(input logic [23:1] a);
    logic [3:0] hit;
    hit = '0;
    if ((a[23:7] == gpib_glue_pkg::PORT_REGION
        && (a[6:4] == 3'(gpib_glue_pkg::STB_GENERAL)
        || a[6:4] == 3'(gpib_glue_pkg::STB_SYSTEM)))
        || (a[23:7] == gpib_glue_pkg::LATCH_REGION
        && (a[6:4] == 3'(gpib_glue_pkg::STB_LREAD)
        || a[6:4] == 3'(gpib_glue_pkg::STB_LWRITE)))) begin
      hit[a[5:4]] = 1'b1;
    end
    return hit;
  endfunction

  // which wire lines a port drives, from talk, controller and atn
  function automatic logic [7:0] ctl_dir(input logic talk, input logic ctrl,
      input logic atn);
    logic [7:0] d;
    d = '0;
    d[gpib_glue_pkg::CTL_DAV] = talk;
    d[gpib_glue_pkg::CTL_NRFD] = !talk;
    d[gpib_glue_pkg::CTL_NDAC] = !talk;
    d[gpib_glue_pkg::CTL_ATN] = ctrl;
    d[gpib_glue_pkg::CTL_IFC] = ctrl;
    d[gpib_glue_pkg::CTL_REN] = ctrl;
    d[gpib_glue_pkg::CTL_SRQ] = !ctrl;
    d[gpib_glue_pkg::CTL_EOI] = (talk && !atn) || (ctrl && atn);
    return d;
  endfunction

  // synchroniser stages for every pin input
  logic [SYNC_W-1:0] meta_q, meta_d, sync_q, sync_d;
  // synchronised views
  logic ios_n_s, wr_n_s, clk5_s;
  logic [23:1] addr_s;
  logic [15:0] data_s;
  logic [1:0][7:0] ctl_n_s, dio_n_s;

  // access state
  logic ios_prev_q, ios_prev_d; // last strobe level, for edges
  logic clk5_prev_q, clk5_prev_d; // last host clock level
  logic [3:0] sel_q, sel_d; // active-high strobes
  logic [2:0] idx_q, idx_d; // register index held for the access
  logic wr_n_q, wr_n_d; // direction held for the access
  logic [15:0] latch_q, latch_d; // self-test latch
  logic [15:0] dout_q, dout_d, oe_q, oe_d;

  // pin driver state
  logic [1:0][7:0] dio_out_q, dio_out_d, dio_oe_q, dio_oe_d;
  logic [1:0][7:0] ctl_out_q, ctl_out_d, ctl_oe_q, ctl_oe_d;
  logic [1:0] te_q, te_d;

  // per-port traffic
  logic strobe_on, start, finish, tick;
  logic [3:0] hit;
  logic [NP-1:0] port_wr, port_rd_done, port_talk, port_ctrl, port_srq_n;
  logic [NP-1:0][7:0] port_rdata, port_dio_drive, port_ctl_assert;
  logic [2:0] port_idx;

  // two flops on every pin; the first stage feeds only the second
  always_comb begin
    meta_d = {io_strobe_n, write_n, host_clk5, host_addr, host_data_in,
      gpib_ctl_n_in, gpib_dio_n_in};
    sync_d = meta_q;
  end

  // synchroniser registers; idle lines rest high
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= '1;
      sync_q <= '1;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  // address and data are sampled with the strobe; the host must set them
  // up before the strobe falls, since skew between lanes is not filtered
  assign {ios_n_s, wr_n_s, clk5_s, addr_s, data_s, ctl_n_s, dio_n_s} = sync_q;

  assign strobe_on = !ios_n_s;
  assign start = strobe_on && ios_prev_q;
  assign finish = !strobe_on && !ios_prev_q;
  assign tick = clk5_s && !clk5_prev_q;
  assign hit = decode_sel(addr_s);
  assign port_idx = strobe_on ? addr_s[3:1] : idx_q;

  // next values of the host access group
  always_comb begin
    ios_prev_d = ios_n_s;
    clk5_prev_d = clk5_s;
    sel_d = strobe_on ? hit : '0;
    idx_d = strobe_on ? addr_s[3:1] : idx_q;
    wr_n_d = strobe_on ? wr_n_s : wr_n_q;
    latch_d = latch_q;
    // latch captures the lanes at the start of a latch write
    if (start && !wr_n_s && hit[gpib_glue_pkg::STB_LWRITE]) begin
      latch_d = data_s;
    end
    dout_d = dout_q;
    oe_d = '0;
    // lanes are driven only for a decoded read
    if (strobe_on && wr_n_s) begin
      if (hit[gpib_glue_pkg::STB_LREAD]) begin
        dout_d = latch_q;
        oe_d = '1;
      end
      for (int p = 0; p < NP; p++) begin
        if (hit[p]) begin
          dout_d[p*BW +: BW] = port_rdata[p];
          oe_d[p*BW +: BW] = '1;
        end
      end
    end
  end

  // host access registers
  always_ff @(posedge clk) begin
    if (rst) begin
      ios_prev_q <= 1'b1;
      clk5_prev_q <= 1'b1;
      sel_q <= '0;
      idx_q <= '0;
      wr_n_q <= 1'b1;
      latch_q <= '0;
      dout_q <= '0;
      oe_q <= '0;
    end else begin
      ios_prev_q <= ios_prev_d;
      clk5_prev_q <= clk5_prev_d;
      sel_q <= sel_d;
      idx_q <= idx_d;
      wr_n_q <= wr_n_d;
      latch_q <= latch_d;
      dout_q <= dout_d;
      oe_q <= oe_d;
    end
  end

  // a write reaches the port at strobe start; a read is closed at the end
  // so the byte is not consumed before the host has taken it
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      port_wr[p] = start && !wr_n_s && hit[p];
      port_rd_done[p] = finish && sel_q[p] && wr_n_q;
    end
  end

  // next values of the wire drivers
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      // three-state lines drive both levels, open collector only low
      ctl_oe_d[p] = ctl_dir(port_talk[p], port_ctrl[p],
        port_ctl_assert[p][gpib_glue_pkg::CTL_ATN])
        & (gpib_glue_pkg::CTL_TRISTATE | port_ctl_assert[p]);
      ctl_out_d[p] = ~port_ctl_assert[p];
      dio_oe_d[p] = {BW{port_talk[p]}};
      dio_out_d[p] = ~port_dio_drive[p];
    end
    te_d = port_talk;
  end

  // wire driver registers; everything released in reset
  always_ff @(posedge clk) begin
    if (rst) begin
      dio_out_q <= '1;
      dio_oe_q <= '0;
      ctl_out_q <= '1;
      ctl_oe_q <= '0;
      te_q <= '0;
    end else begin
      dio_out_q <= dio_out_d;
      dio_oe_q <= dio_oe_d;
      ctl_out_q <= ctl_out_d;
      ctl_oe_q <= ctl_oe_d;
      te_q <= te_d;
    end
  end

  // both controllers see the same index; only the selected one acts
  for (genvar p = 0; p < NP; p++) begin : g_port
    port_link_if lnk ();
    assign lnk.wr = port_wr[p];
    assign lnk.rd_done = port_rd_done[p];
    assign lnk.idx = port_idx;
    assign lnk.wdata = data_s[p*BW +: BW];
    assign lnk.tick = tick;
    assign lnk.ctl_seen = ~ctl_n_s[p];
    assign lnk.dio_seen = ~dio_n_s[p];
    assign port_rdata[p] = lnk.rdata;
    assign port_ctl_assert[p] = lnk.ctl_assert;
    assign port_dio_drive[p] = lnk.dio_drive;
    assign port_talk[p] = lnk.talk;
    assign port_ctrl[p] = lnk.ctrl;
    assign port_srq_n[p] = lnk.srq_n;
    gpib_port u_port (
      .clk(clk),
      .rst(rst),
      .lnk(lnk)
    );
  end

  // outputs; talk enable reads high while the port talks
  assign general_port_select_n = !sel_q[gpib_glue_pkg::STB_GENERAL];
  assign system_port_select_n = !sel_q[gpib_glue_pkg::STB_SYSTEM];
  assign test_latch_read_n = !sel_q[gpib_glue_pkg::STB_LREAD];
  assign test_latch_write_n = !sel_q[gpib_glue_pkg::STB_LWRITE];
  assign port_reg_index = idx_q;
  assign general_port_service_req_n = port_srq_n[0];
  assign system_port_service_req_n = port_srq_n[1];
  assign talk_enable_n = te_q;
  assign host_data_out = dout_q;
  assign host_data_oe = oe_q;
  assign gpib_dio_n_out = dio_out_q;
  assign gpib_dio_oe = dio_oe_q;
  assign gpib_ctl_n_out = ctl_out_q;
  assign gpib_ctl_oe = ctl_oe_q;

  default clocking top_cb @(posedge clk); endclocking
  default disable iff (rst);

  a_one_strobe_only: assert property ($onehot0(sel_q))
    else $error("more than one select strobe active");
  a_strobe_needs_ios: assert property (
    (sel_q != '0) |-> $past(strobe_on))
    else $error("select strobe without io strobe");
  a_general_decode: assert property (
    (strobe_on && addr_s[23:7] == gpib_glue_pkg::PORT_REGION && addr_s[6:4] == 3'h0)
      |=> !general_port_select_n && system_port_select_n)
    else $error("general port select not decoded");
  a_system_decode: assert property (
    (strobe_on && addr_s[23:7] == gpib_glue_pkg::PORT_REGION && addr_s[6:4] == 3'h1)
      |=> !system_port_select_n && general_port_select_n)
    else $error("system port select not decoded");
  a_latch_roundtrip: assert property (
    (strobe_on && wr_n_s && hit[gpib_glue_pkg::STB_LREAD])
      |=> host_data_out == $past(latch_q) && host_data_oe == '1)
    else $error("latch read does not return stored value");
  a_latch_capture: assert property (
    (start && !wr_n_s && hit[gpib_glue_pkg::STB_LWRITE]) |=> latch_q == $past(data_s))
    else $error("latch write did not capture the data lanes");
  a_latch_addr: assert property (
    $fell(test_latch_write_n) |-> $past(addr_s[23:7]) == gpib_glue_pkg::LATCH_REGION
      && $past(addr_s[6:4]) == 3'h3)
    else $error("latch write strobe at wrong address");
  a_lanes_released: assert property (
    (!strobe_on || !wr_n_s || hit == '0) |=> host_data_oe == '0)
    else $error("data lanes driven with no read selected");
  a_general_low_lane: assert property (
    (strobe_on && wr_n_s && hit[gpib_glue_pkg::STB_GENERAL])
      |=> host_data_oe == 16'h00FF && host_data_out[7:0] == $past(port_rdata[0]))
    else $error("general port read not on low lanes");
  a_system_high_lane: assert property (
    (strobe_on && wr_n_s && hit[gpib_glue_pkg::STB_SYSTEM])
      |=> host_data_oe == 16'hFF00 && host_data_out[15:8] == $past(port_rdata[1]))
    else $error("system port read not on high lanes");
  a_index_routed: assert property (
    strobe_on |=> port_reg_index == $past(addr_s[3:1]))
    else $error("register index not passed to ports");
  a_dio_follows_talk: assert property (
    ##1 gpib_dio_oe[0] == {8{$past(port_talk[0])}} && talk_enable_n[0] == $past(port_talk[0]))
    else $error("data transceiver direction does not follow talk");
  a_listen_no_dav: assert property (
    !port_talk[1] |=> !gpib_ctl_oe[1][gpib_glue_pkg::CTL_DAV])
    else $error("data valid driven while listening");
endmodule
`default_nettype wire

// File: dv/host_bus_model.sv
// host processor model driving the instrument bus
`timescale 1ns/10ps
`default_nettype none
module host_bus_model (
  input wire logic clk,
  output logic [23:1] host_addr,
  output logic [15:0] host_data_in,
  output logic io_strobe_n,
  output logic write_n,
  input wire logic [15:0] host_data_out,
  input wire logic [15:0] host_data_oe
);
  initial begin
    host_addr = 23'h000000;
    host_data_in = 16'h0000;
    io_strobe_n = 1'b1;
    write_n = 1'b1;
  end
  // one access; address and data settle two cycles before the strobe falls
  task automatic access(input logic [23:0] a, input logic [15:0] wd, input logic wr,
      output logic [15:0] rd, output logic [15:0] oe);
    @(posedge clk);
    host_addr <= a[23:1];
    host_data_in <= wr ? wd : ~host_data_in; // lanes driven with their old value inverted on reads
    write_n <= ~wr;
    repeat (2) @(posedge clk);
    io_strobe_n <= 1'b0;
    repeat (5) @(posedge clk);
    rd = host_data_out; // read data stand while the strobe is held
    oe = host_data_oe;
    io_strobe_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// File: dv/tb_gpib_glue_top.sv
// self-checking bench for the dual instrument-port glue
`timescale 1ns/10ps
`default_nettype none
module tb_gpib_glue_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic host_clk5 = 1'b0;
  logic [23:1] host_addr;
  logic [15:0] host_data_in, host_data_out, host_data_oe, rd, oe, lat;
  logic io_strobe_n, write_n;
  logic [3:0] sel_n;
  logic [3:0] seen = 4'h0; // sticky record of strobes seen low
  logic [2:0] idx;
  logic [1:0] ten_n;
  logic [1:0][7:0] dio_out, dio_oe, ctl_out, ctl_oe;
  logic dav_seen = 1'b0;
  logic [7:0] dav_dio;
  logic [7:0] far_ctl_n = 8'hFF; // general port wire lines, low = asserted
  logic [7:0] far_dio_n = 8'hFF; // general port wire data, low = one
  logic [1:0] srq_n; // service requests to the host
  int fail_count = 0;
  int total_checks = 0;
  always #5 clk = ~clk;
  always #100 host_clk5 = ~host_clk5;
  // system wire released, pull-ups read high; general wire driven by far_send
  gpib_glue_top i_gpib_glue_top (.clk(clk), .rst(rst), .host_addr(host_addr),
    .host_data_in(host_data_in), .host_data_out(host_data_out), .host_data_oe(host_data_oe),
    .io_strobe_n(io_strobe_n), .write_n(write_n), .host_clk5(host_clk5),
    .general_port_select_n(sel_n[0]), .system_port_select_n(sel_n[1]),
    .test_latch_read_n(sel_n[2]), .test_latch_write_n(sel_n[3]), .port_reg_index(idx),
    .general_port_service_req_n(srq_n[0]), .system_port_service_req_n(srq_n[1]),
    .talk_enable_n(ten_n),
    .gpib_dio_n_in({8'hFF, far_dio_n}), .gpib_dio_n_out(dio_out), .gpib_dio_oe(dio_oe),
    .gpib_ctl_n_in({8'hFF, far_ctl_n}), .gpib_ctl_n_out(ctl_out), .gpib_ctl_oe(ctl_oe));
  host_bus_model i_host_bus_model (.clk(clk), .host_addr(host_addr),
    .host_data_in(host_data_in), .io_strobe_n(io_strobe_n), .write_n(write_n),
    .host_data_out(host_data_out), .host_data_oe(host_data_oe));
  // catch short strobes and the byte present while data valid is asserted
  always @(posedge clk) begin
    seen <= seen | ~sel_n;
    if (ctl_out[0][0] === 1'b0) begin
      dav_seen <= 1'b1;
      dav_dio <= dio_out[0];
    end
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // strobe expected for an address: {latch write, latch read, system, general}
  function automatic logic [3:0] exp_sel(input logic [23:0] a);
    exp_sel = {a[23:4] == 20'h1FF93, a[23:4] == 20'h1FF92, a[23:4] == 20'h1FE11,
      a[23:4] == 20'h1FE10};
  endfunction
  // one access with checks on strobes, register index and lane drive
  task automatic bus(input logic [23:0] a, input logic [15:0] wd, input logic wr,
      input logic [15:0] erd, input logic [15:0] eoe);
    @(negedge clk) seen = 4'h0;
    i_host_bus_model.access(a, wd, wr, rd, oe);
    check(oe, eoe);
    if (eoe != 16'h0000) check(rd & eoe, erd);
    check({12'h000, seen}, {12'h000, exp_sel(a)});
    if (seen[1:0] != 2'b00) check({13'h0000, idx}, {13'h0000, a[3:1]});
  endtask
  // far talker: byte and atn, then data valid after a fixed settle, then release;
  // a refused byte is offered anyway so the acceptor is tested
  task automatic far_send(input logic [7:0] b, input logic atn);
    @(posedge clk);
    far_dio_n <= ~b;
    far_ctl_n <= {4'hF, ~atn, 3'h7};
    repeat (4) @(posedge clk);
    far_ctl_n[0] <= 1'b0;
    repeat (8) @(posedge clk);
    far_ctl_n <= 8'hFF;
    far_dio_n <= 8'hFF;
    repeat (8) @(posedge clk);
  endtask
  task automatic stop_test;
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    void'($urandom(2530));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    // latch: zeros, ones, walking one, then random patterns
    for (int i = 0; i < 38; i++) begin
      lat = (i == 0) ? 16'h0000 : (i == 1) ? 16'hFFFF : (i < 18) ? 16'h0001 << (i - 2)
        : 16'($urandom);
      bus(24'h1FF930, lat, 1'b1, 16'h0000, 16'h0000);
      bus(24'h1FF920, 16'h0000, 1'b0, lat, 16'hFFFF);
    end
    $display("latch test done");
    // unused code in the latch window, then random unmapped places
    bus(24'h1FF940, 16'h1234, 1'b0, 16'h0000, 16'h0000);
    for (int i = 0; i < 10; i++) begin
      bus({4'h0, 20'($urandom)}, 16'($urandom), i[0], 16'h0000, 16'h0000);
    end
    $display("unmapped test done");
    // receive: refused before addressing, then listen, byte, read, unlisten
    bus(24'h1FE102, 16'h0005, 1'b1, 16'h0000, 16'h0000);
    far_send(8'h77, 1'b0);
    check({14'h0000, srq_n}, 16'h0003);
    far_send(8'h25, 1'b1);
    far_send(8'hC3, 1'b0);
    check({14'h0000, srq_n}, 16'h0002);
    bus(24'h1FE100, 16'h0000, 1'b0, 16'h00C3, 16'h00FF);
    check({14'h0000, srq_n}, 16'h0003);
    far_send(8'h3F, 1'b1);
    $display("receive test done");
    // general port talks only; system port talks and is controller
    bus(24'h1FE104, 16'h0001, 1'b1, 16'h0000, 16'h0000);
    bus(24'h1FE114, 16'h3F00, 1'b1, 16'h0000, 16'h0000);
    check({14'h0000, ten_n}, 16'h0003);
    check({dio_oe[1], dio_oe[0]}, 16'hFFFF);
    check({ctl_out[1] & 8'h68, ctl_out[0] & 8'h68}, 16'h0068);
    bus(24'h1FE102, 16'h0000, 1'b0, 16'h0008, 16'h00FF);
    bus(24'h1FE112, 16'h0000, 1'b0, 16'h1800, 16'hFF00);
    // one byte out; settle time is ten host clock periods
    bus(24'h1FE100, 16'h00A5, 1'b1, 16'h0000, 16'h0000);
    repeat (400) @(posedge clk);
    check({15'h0000, dav_seen}, 16'h0001);
    check({8'h00, dav_dio}, 16'h005A);
    $display("port test done");
    stop_test();
  end
  // watchdog well beyond the expected run
  initial begin
    #100000;
    fail_count++;
    stop_test();
  end
endmodule
`default_nettype wire
